// >>> dv/sdl_diag_logger_sva.sv
`timescale 1ns/10ps
`include "sdl_defines.svh"
module sdl_diag_logger_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [31:0] rdata,
  input wire logic [9:0] addr_switch,
  input wire logic comm_error,
  input wire logic nv_addr_we,
  input wire logic [15:0] nv_addr_data,
  input wire logic nv_ptr_we,
  input wire logic io_tick,
  input wire logic emcy_valid,
  input wire logic [63:0] emcy_data,
  input wire logic emcy_ready,
  input wire logic [15:0] node_addr
);
  logic [15:0] w_lo;
  logic raise_wr;
  assign w_lo = wdata[15:0];
  assign raise_wr = wr_strobe && addr == `SDL_REG_ERR_RAISE;
  // ==========
  // Checks.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  a_read_slot: assert property (!$past(rd_strobe) |-> rdata == 32'h0)
    else $error("rdata outside slot");
  a_emcy_gate: assert property (comm_error |-> !emcy_valid)
    else $error("emcy during comm error");
  a_emcy_hold: assert property (emcy_valid && !emcy_ready |=> (emcy_valid || comm_error) && $stable(emcy_data))
    else $error("emcy dropped");
  a_emcy_rsvd: assert property (emcy_valid |-> emcy_data[31:24] == 8'h00)
    else $error("emcy reserved byte");
  a_tick_pulse: assert property (io_tick |=> !io_tick)
    else $error("tick too long");
  a_log_raise: assert property (raise_wr && !wdata[1] |=> nv_ptr_we)
    else $error("error not logged");
  a_mem_skip: assert property (raise_wr && wdata[1] |=> !nv_ptr_we)
    else $error("memory error logged");
  a_addr_save: assert property (wr_strobe && addr == `SDL_REG_NODE_SET |=> nv_addr_we && nv_addr_data == $past(w_lo))
    else $error("address not saved");
  a_switch_use: assert property (($stable(addr_switch) && addr_switch != 10'h000) [*6] |-> node_addr == {6'h00, addr_switch})
    else $error("switch address");
endmodule : sdl_diag_logger_sva
bind sdl_diag_logger sdl_diag_logger_sva sdl_diag_logger_sva_inst (.*);

// >>> dv/sdl_diag_logger_tb_top.sv
`timescale 1ns/10ps
`include "sdl_defines.svh"
module sdl_diag_logger_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic sync_pin = 1'b0;
  logic [9:0] addr_switch = 10'h000;
  logic comm_error = 1'b0;
  logic sii_ok = 1'b1;
  logic slow = 1'b0;
  logic [31:0] rdata, serial_nv;
  logic [15:0] node_addr_nv, nv_addr_data, node_addr;
  logic [2:0] hist_ptr_nv, nv_ptr_data;
  logic nv_valid, nv_addr_we, nv_ptr_we, io_tick, emcy_valid, emcy_ready, irq;
  logic [63:0] emcy_data;
  int n_fail = 0;
  int samples_checked = 0;
  int ticks = 0;
  sdl_diag_logger #(.FREE_RUN_CYCLES(20)) sdl_diag_logger_inst (.*);
  sdl_nv_model sdl_nv_model_inst (.*);
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (io_tick === 1'b1) begin
      ticks++;
    end
  end
  // ==========
  // Shared tasks.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask : rdc
  task automatic raise(input logic [15:0] code, input logic mem);
    wr(`SDL_REG_ERR_CODE, {8'h00, 8'h11, code});
    wr(`SDL_REG_ERR_RAISE, {30'h0, mem, 1'b0});
  endtask : raise
  task automatic look(input logic e, input logic [15:0] code);
    logic got;
    logic [63:0] d;
    got = 1'b0;
    d = 64'h0;
    repeat (8) begin
      #1;
      if (emcy_valid === 1'b1 && !got) begin
        got = 1'b1;
        d = emcy_data;
      end
      @(posedge sys_clk);
    end
    chk("emcy_valid", {31'h0, e}, {31'h0, got});
    if (e) begin
      chk("emcy_lo", {16'h0011, code}, d[31:0]);
      chk("emcy_hi", 32'hcafe0001, d[63:32]);
    end
  endtask : look
  // ==========
  // Scenarios.
  task automatic s_node;
    repeat (4) @(posedge sys_clk);
    chk("node_soft", 32'h0123, {16'h0, node_addr});
    wr(`SDL_REG_NODE_SET, 32'h0456);
    repeat (3) @(posedge sys_clk);
    chk("node_saved", 32'h0456, {16'h0, node_addr});
    addr_switch <= 10'h3e7;
    repeat (8) @(posedge sys_clk);
    chk("node_sw", 32'h3e7, {16'h0, node_addr});
    addr_switch <= 10'h000;
  endtask : s_node
  task automatic s_hist;
    for (int i = 1; i <= 9; i++) begin
      raise(i[15:0], 1'b0);
    end
    raise(16'h00ee, 1'b1);
    chk("ptr", 32'h1, {29'h0, hist_ptr_nv});
    rdc(`SDL_REG_HIST_BASE, 32'h00110009, "slot1");
    rdc(`SDL_REG_HIST_BASE + 8'h08, 32'h00110002, "slot2");
    rdc(`SDL_REG_HIST_BASE + 8'h38, 32'h00110008, "slot8");
  endtask : s_hist
  task automatic s_emcy;
    rdc(`SDL_REG_NOTIFY, 32'h0, "notify_rst");
    wr(`SDL_REG_ERR_STAT, 32'hcafe0001);
    raise(16'h1001, 1'b0);
    look(1'b0, 16'h0);
    wr(`SDL_REG_NOTIFY, 32'h2);
    rdc(`SDL_REG_NOTIFY, 32'h0, "notify_bad");
    wr(`SDL_REG_NOTIFY, 32'h1);
    slow <= 1'b1;
    raise(16'h2002, 1'b0);
    look(1'b1, 16'h2002);
    slow <= 1'b0;
    comm_error <= 1'b1;
    raise(16'h3003, 1'b0);
    look(1'b0, 16'h0);
    comm_error <= 1'b0;
    wr(`SDL_REG_NOTIFY, 32'h0);
    repeat (8) @(posedge sys_clk);
  endtask : s_emcy
  task automatic s_regs;
    rdc(`SDL_REG_SERIAL, 32'h0000a5c3, "serial");
    wr(`SDL_REG_SERIAL, 32'h0);
    rdc(`SDL_REG_SERIAL, 32'h0000a5c3, "serial_ro");
    wr(`SDL_REG_IRQ_MASK, 32'h4);
    raise(16'h0777, 1'b0);
    #1 chk("irq_set", 32'h1, {31'h0, irq});
    wr(`SDL_REG_IRQ_STAT, 32'h4);
    #1 chk("irq_clr", 32'h0, {31'h0, irq});
    wr(`SDL_REG_IRQ_MASK, 32'h0);
    raise(16'h0778, 1'b0);
    #1 chk("irq_mask", 32'h0, {31'h0, irq});
    wr(`SDL_REG_IRQ_STAT, 32'hf);
    wr(8'h38, 32'hffff);
    rdc(`SDL_REG_NOTIFY, 32'h0, "unmapped");
    sii_ok <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rdc(`SDL_REG_CTRL, 32'h16, "sii_bad");
    rdc(`SDL_REG_IRQ_STAT, 32'h8, "sii_irq");
    sii_ok <= 1'b1;
    wr(`SDL_REG_IRQ_STAT, 32'hf);
  endtask : s_regs
  task automatic s_sync;
    int t;
    logic [31:0] d;
    #1 t = ticks;
    repeat (60) @(posedge sys_clk);
    #1 chk("free_ticks", 32'h3, ticks - t);
    wr(`SDL_REG_CTRL, 32'h1);
    #1 t = ticks;
    repeat (40) @(posedge sys_clk);
    #1 chk("dc_quiet", 32'h0, ticks - t);
    @(posedge sys_clk);
    sync_pin <= 1'b1;
    #1 t = ticks;
    repeat (8) @(posedge sys_clk);
    #1 chk("dc_tick", 32'h1, ticks - t);
    sync_pin <= 1'b0;
    wr(`SDL_REG_CTRL, 32'hd);
    rd(`SDL_REG_CTRL, d);
    chk("period_bad", 32'h1, {28'h0, d[3:0]});
    wr(`SDL_REG_CTRL, 32'h6);
    rd(`SDL_REG_CTRL, d);
    chk("period_ok", 32'h6, {28'h0, d[3:0]});
  endtask : s_sync
  task automatic complete_run;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    s_node();
    s_hist();
    s_emcy();
    s_regs();
    s_sync();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
endmodule : sdl_diag_logger_tb_top

// >>> dv/sdl_nv_model.sv
`timescale 1ns/10ps
module sdl_nv_model #(
  parameter logic [31:0] SERIAL = 32'h0000a5c3,
  parameter logic [15:0] SOFT_ADDR = 16'h0123
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic nv_addr_we,
  input wire logic [15:0] nv_addr_data,
  input wire logic nv_ptr_we,
  input wire logic [2:0] nv_ptr_data,
  output logic [31:0] serial_nv,
  output logic [15:0] node_addr_nv = SOFT_ADDR,
  output logic [2:0] hist_ptr_nv = 3'h0,
  output logic nv_valid = 1'b0,
  output logic emcy_ready = 1'b0
);
  logic [1:0] cnt = 2'h0;
  assign serial_nv = SERIAL;
  // ==========
  // Memory and emergency sink.
  always @(posedge sys_clk) begin
    cnt <= cnt + 2'h1;
    nv_valid <= !reset;
    emcy_ready <= !slow || cnt == 2'h3;
    if (nv_addr_we) begin
      node_addr_nv <= nv_addr_data;
    end
    if (nv_ptr_we) begin
      hist_ptr_nv <= nv_ptr_data;
    end
  end
endmodule : sdl_nv_model

// >>> rtl/sdl_defines.svh
`ifndef SDL_DEFINES_SVH
`define SDL_DEFINES_SVH
// ==========================================================================
// Register offsets.
`define SDL_REG_CTRL 8'h00
`define SDL_REG_NOTIFY 8'h04
`define SDL_REG_STATUS 8'h08
`define SDL_REG_IRQ_STAT 8'h0c
`define SDL_REG_IRQ_MASK 8'h10
`define SDL_REG_ERR_CODE 8'h14
`define SDL_REG_ERR_STAT 8'h18
`define SDL_REG_ERR_RAISE 8'h1c
`define SDL_REG_SERIAL 8'h20
`define SDL_REG_NODE_ADDR 8'h24
`define SDL_REG_NODE_SET 8'h28
`define SDL_REG_HIST_PTR 8'h2c
`define SDL_REG_EMCY_LO 8'h30
`define SDL_REG_EMCY_HI 8'h34
`define SDL_REG_HIST_BASE 8'h40
// ==========================================================================
// Control field positions.
`define SDL_CTRL_DC_BIT 0
`define SDL_CTRL_PERIOD_LSB 1
`define SDL_CTRL_SII_OK_BIT 4
// ==========================================================================
// Notification enable values.
`define SDL_NOTIFY_OFF 16'h0000
`define SDL_NOTIFY_ON 16'h0001
// ==========================================================================
// Interrupt status bits.
`define SDL_IRQ_CYCLE 0
`define SDL_IRQ_EMCY 1
`define SDL_IRQ_LOGGED 2
`define SDL_IRQ_SII_BAD 3
// ==========================================================================
// Timing.
`define SDL_CLK_HZ 25000000
`define SDL_PERIOD_125US_NS 125000
`define SDL_PERIOD_250US_NS 250000
`define SDL_PERIOD_500US_NS 500000
`define SDL_PERIOD_1MS_NS 1000000
`define SDL_PERIOD_2MS_NS 2000000
`define SDL_PERIOD_4MS_NS 4000000
`define SDL_CLK_NS 40
`define SDL_FREE_RUN_NS 1000000
`endif

// >>> rtl/sdl_diag_logger.sv
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "sdl_defines.svh"
// What this block does
// - Free-run mode processes I/O on an internal timer, unrelated to master cycle.
// - DC mode processes I/O on each sync interrupt from the shared clock.
// - Sync period is only stored and read back; only 125us to 4ms periods are accepted.
// - Notify flag: zero suppresses emergency messages, one enables them.
// - Notify flag resets to suppress after every power-up.
// - No emergency message goes out during a communication error.
// - Emergency message is eight bytes: code, error register, reserved, status.
// - Eight history messages readable as diagnosis sub-entries six to thirteen.
// - History fills slot one onward and wraps to slot one after eight.
// - Every error other than a memory error is logged even when suppressed or unsendable.
// - Errors of the non-volatile memory itself are never logged.
// - Address switches at zero select the stored software node address.
// - Nonzero address switches give the node address directly.
// - A node address write command stores the address persistently.
// - Serial number is exposed read-only.
// - Detected errors are reported in a dedicated error status entry.
// - The device flags a bad stored slave configuration information reported on its sii_ok input.
module sdl_diag_logger #(
  parameter int FREE_RUN_CYCLES = `SDL_FREE_RUN_NS / `SDL_CLK_NS,
  parameter int HIST_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rdata,
  input wire logic sync_pin,
  input wire logic [9:0] addr_switch,
  input wire logic comm_error,
  input wire logic [31:0] serial_nv,
  input wire logic [15:0] node_addr_nv,
  input wire logic [2:0] hist_ptr_nv,
  input wire logic nv_valid,
  input wire logic sii_ok,
  output logic nv_addr_we,
  output logic [15:0] nv_addr_data,
  output logic nv_ptr_we,
  output logic [2:0] nv_ptr_data,
  output logic io_tick,
  output logic emcy_valid,
  output logic [63:0] emcy_data,
  input wire logic emcy_ready,
  output logic [15:0] node_addr,
  output logic irq
);
  // ==========================================================================
  // Cycle counts for each sync period.
  localparam int C125 = `SDL_PERIOD_125US_NS / `SDL_CLK_NS;
  localparam int C250 = `SDL_PERIOD_250US_NS / `SDL_CLK_NS;
  localparam int C500 = `SDL_PERIOD_500US_NS / `SDL_CLK_NS;
  localparam int C1M = `SDL_PERIOD_1MS_NS / `SDL_CLK_NS;
  localparam int C2M = `SDL_PERIOD_2MS_NS / `SDL_CLK_NS;
  localparam int C4M = `SDL_PERIOD_4MS_NS / `SDL_CLK_NS;

  function automatic logic [16:0] period_cycles(input logic [2:0] p);
    unique case (p)
      3'h0: period_cycles = 17'(C125);
      3'h1: period_cycles = 17'(C250);
      3'h2: period_cycles = 17'(C500);
      3'h3: period_cycles = 17'(C1M);
      3'h4: period_cycles = 17'(C2M);
      default: period_cycles = 17'(C4M);
    endcase
  endfunction : period_cycles

  function automatic logic period_legal(input logic [2:0] p);
    period_legal = (p <= 3'h5);
  endfunction : period_legal

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [2:0] sync_sh;
    logic sync_lvl;
    logic [9:0] sw1;
    logic [9:0] sw2;
    logic [9:0] sw3;
    logic [9:0] sw_val;
    logic dc_mode;
    logic [2:0] period;
    logic [16:0] sync_cnt;
    logic [16:0] cycle_len;
    logic [16:0] free_cnt;
    logic tick;
    logic [15:0] notify;
    logic [15:0] err_code;
    logic [31:0] err_stat;
    logic [7:0] err_reg;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [2:0] hist_ptr;
    logic [HIST_DEPTH-1:0][63:0] hist;
    logic [15:0] sw_addr;
    logic [15:0] node;
    logic nv_addr_we;
    logic nv_ptr_we;
    logic loaded;
    logic sii_bad;
    sdl_pkg::sdl_tx_t tx;
    logic [63:0] emcy;
    logic [31:0] rdata;
  } sdl_state_t;

  sdl_state_t s;
  sdl_state_t next_s;
  logic sync_rise;
  logic [63:0] msg;
  logic [9:0] bcd;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    next_s.nv_addr_we = 1'b0;
    next_s.nv_ptr_we = 1'b0;
    next_s.rdata = 32'h0000_0000;
    next_s.sync_sh = {s.sync_sh[1:0], sync_pin};
    // A pin level counts once the second and third stages agree.
    sync_rise = s.sync_sh[1] & s.sync_sh[2] & ~s.sync_lvl;
    if (s.sync_sh[1] == s.sync_sh[2]) begin
      next_s.sync_lvl = s.sync_sh[2];
    end
    next_s.sw1 = addr_switch;
    next_s.sw2 = s.sw1;
    next_s.sw3 = s.sw2;
    if (s.sw2 == s.sw3) begin
      next_s.sw_val = s.sw3;
    end
    bcd = s.sw_val;
    msg = {s.err_stat, 8'h00, s.err_reg, s.err_code};
    // Captures the stored values once the memory reports valid.
    if (!s.loaded && nv_valid) begin
      next_s.loaded = 1'b1;
      next_s.sw_addr = node_addr_nv;
      next_s.hist_ptr = hist_ptr_nv;
    end
    next_s.sii_bad = ~sii_ok;
    if (~sii_ok && !s.sii_bad) begin
      next_s.irq_stat[`SDL_IRQ_SII_BAD] = 1'b1;
    end
    next_s.node = (bcd == 10'h000) ? s.sw_addr : {6'h00, bcd};
    // Free-run timer versus sync interrupt.
    if (s.dc_mode) begin
      next_s.free_cnt = 17'h0_0000;
      if (sync_rise) begin
        next_s.tick = 1'b1;
        next_s.cycle_len = s.sync_cnt + 17'h0_0001;
        next_s.sync_cnt = 17'h0_0000;
        next_s.irq_stat[`SDL_IRQ_CYCLE] = 1'b1;
      end else if (s.sync_cnt != 17'h1_ffff) begin
        next_s.sync_cnt = s.sync_cnt + 17'h0_0001;
      end
    end else begin
      if (s.free_cnt >= 17'(FREE_RUN_CYCLES - 1)) begin
        next_s.free_cnt = 17'h0_0000;
        next_s.tick = 1'b1;
      end else begin
        next_s.free_cnt = s.free_cnt + 17'h0_0001;
      end
    end
    // Emergency transmit.
    unique case (s.tx)
      sdl_pkg::SDL_TX_IDLE: ;
      sdl_pkg::SDL_TX_SEND: begin
        if (comm_error) begin
          next_s.tx = sdl_pkg::SDL_TX_IDLE;
        end else if (emcy_ready) begin
          next_s.tx = sdl_pkg::SDL_TX_IDLE;
          next_s.irq_stat[`SDL_IRQ_EMCY] = 1'b1;
        end
      end
      sdl_pkg::SDL_TX_WAIT: next_s.tx = sdl_pkg::SDL_TX_IDLE;
    endcase
    // Register writes.
    if (wr_strobe) begin
      unique case (addr)
        `SDL_REG_CTRL: begin
          next_s.dc_mode = wdata[`SDL_CTRL_DC_BIT];
          if (period_legal(wdata[`SDL_CTRL_PERIOD_LSB +: 3])) begin
            next_s.period = wdata[`SDL_CTRL_PERIOD_LSB +: 3];
          end
        end
        `SDL_REG_NOTIFY: begin
          if (wdata[15:0] == `SDL_NOTIFY_OFF || wdata[15:0] == `SDL_NOTIFY_ON) begin
            next_s.notify = wdata[15:0];
          end
        end
        `SDL_REG_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~wdata[3:0];
        `SDL_REG_IRQ_MASK: next_s.irq_mask = wdata[3:0];
        `SDL_REG_ERR_CODE: begin
          next_s.err_code = wdata[15:0];
          next_s.err_reg = wdata[23:16];
        end
        `SDL_REG_ERR_STAT: next_s.err_stat = wdata;
        `SDL_REG_ERR_RAISE: begin
          if (!wdata[1]) begin
            next_s.hist[s.hist_ptr] = msg;
            next_s.hist_ptr = (s.hist_ptr == 3'(HIST_DEPTH - 1)) ? 3'h0 : s.hist_ptr + 3'h1;
            next_s.nv_ptr_we = 1'b1;
            next_s.irq_stat[`SDL_IRQ_LOGGED] = 1'b1;
          end
          if (s.notify == `SDL_NOTIFY_ON && !comm_error) begin
            next_s.emcy = msg;
            next_s.tx = sdl_pkg::SDL_TX_SEND;
          end
        end
        `SDL_REG_NODE_SET: begin
          next_s.sw_addr = wdata[15:0];
          next_s.nv_addr_we = 1'b1;
        end
        default: ;
      endcase
    end
    // Event sets win over the clear above.
    if (sync_rise && s.dc_mode) begin
      next_s.irq_stat[`SDL_IRQ_CYCLE] = 1'b1;
    end
    if (s.tx == sdl_pkg::SDL_TX_SEND && emcy_ready && !comm_error) begin
      next_s.irq_stat[`SDL_IRQ_EMCY] = 1'b1;
    end
    if (~sii_ok && !s.sii_bad) begin
      next_s.irq_stat[`SDL_IRQ_SII_BAD] = 1'b1;
    end
    // Register reads.
    if (rd_strobe) begin
      if (addr >= `SDL_REG_HIST_BASE && addr < 8'(`SDL_REG_HIST_BASE + 8 * HIST_DEPTH)) begin
        next_s.rdata = addr[2] ? s.hist[addr[5:3]][63:32] : s.hist[addr[5:3]][31:0];
      end else begin
        unique case (addr)
          `SDL_REG_CTRL: next_s.rdata = {27'h0, s.sii_bad, s.period, s.dc_mode};
          `SDL_REG_NOTIFY: next_s.rdata = {16'h0000, s.notify};
          `SDL_REG_STATUS: next_s.rdata = {15'h0, s.cycle_len};
          `SDL_REG_IRQ_STAT: next_s.rdata = {28'h0, s.irq_stat};
          `SDL_REG_IRQ_MASK: next_s.rdata = {28'h0, s.irq_mask};
          `SDL_REG_ERR_CODE: next_s.rdata = {8'h00, s.err_reg, s.err_code};
          `SDL_REG_ERR_STAT: next_s.rdata = s.err_stat;
          `SDL_REG_SERIAL: next_s.rdata = serial_nv;
          `SDL_REG_NODE_ADDR: next_s.rdata = {16'h0000, s.node};
          `SDL_REG_HIST_PTR: next_s.rdata = {29'h0, s.hist_ptr};
          `SDL_REG_EMCY_LO: next_s.rdata = s.emcy[31:0];
          `SDL_REG_EMCY_HI: next_s.rdata = s.emcy[63:32];
          default: next_s.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
      s.notify <= `SDL_NOTIFY_OFF;
      s.period <= 3'h3;
      s.tx <= sdl_pkg::SDL_TX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign io_tick = s.tick;
  assign emcy_valid = (s.tx == sdl_pkg::SDL_TX_SEND) && !comm_error;
  assign emcy_data = s.emcy;
  assign node_addr = s.node;
  assign nv_addr_we = s.nv_addr_we;
  assign nv_addr_data = s.sw_addr;
  assign nv_ptr_we = s.nv_ptr_we;
  assign nv_ptr_data = s.hist_ptr;
  assign irq = |(s.irq_stat & s.irq_mask);
endmodule : sdl_diag_logger

// >>> rtl/sdl_pkg.sv
package sdl_pkg;
  // ==========================================================================
  // Supported sync periods.
  typedef enum logic [2:0] {
    SDL_P125US,
    SDL_P250US,
    SDL_P500US,
    SDL_P1MS,
    SDL_P2MS,
    SDL_P4MS
  } sdl_period_t;
  // ==========================================================================
  // Emergency transmit state.
  typedef enum logic [1:0] {
    SDL_TX_IDLE,
    SDL_TX_SEND,
    SDL_TX_WAIT
  } sdl_tx_t;
endpackage : sdl_pkg
